// ==== tmr_defines.svh ====
// Register offsets, field positions, reset values, the control B mask and BOTTOM.
`ifndef TMR_DEFINES_SVH
`define TMR_DEFINES_SVH
`define TMR_ADDR_CTRL_A 6'h0f
`define TMR_ADDR_CTRL_B 6'h0e
`define TMR_ADDR_COUNT_L 6'h0c
`define TMR_ADDR_COUNT_H 6'h0d
`define TMR_ADDR_CMPA_L 6'h06
`define TMR_ADDR_CMPA_H 6'h07
`define TMR_ADDR_CMPB_L 6'h08
`define TMR_ADDR_CMPB_H 6'h09
`define TMR_ADDR_CAPT_L 6'h04
`define TMR_ADDR_CAPT_H 6'h05
`define TMR_MODE_A_HI 7
`define TMR_MODE_A_LO 6
`define TMR_MODE_B_HI 5
`define TMR_MODE_B_LO 4
`define TMR_WGM_LO_HI 1
`define TMR_WGM_HI_HI 4
`define TMR_WGM_HI_LO 3
`define TMR_CTRL_RESET 8'h00
`define TMR_CTRL_B_MASK 8'hdf
`define TMR_BOTTOM 16'h0000
`endif

// ==== tmr_pkg.sv ====
// Types shared by the timer byte-access and compare-output logic.
package tmr_pkg;
  typedef enum logic [1:0] {
    TMR_WAVE_NONPWM = 2'b00,
    TMR_WAVE_FAST = 2'b01,
    TMR_WAVE_DUAL = 2'b10
  } tmr_wave_t;
  typedef enum logic [1:0] {
    TMR_OUT_OFF = 2'b00,
    TMR_OUT_TOGGLE = 2'b01,
    TMR_OUT_CLEAR = 2'b10,
    TMR_OUT_SET = 2'b11
  } tmr_out_mode_t;
endpackage : tmr_pkg

// ==== tmr_wave_ch.sv ====
// One compare-output channel: output mode decode and waveform register.
`timescale 1ns/10ps
`include "tmr_defines.svh"
module tmr_wave_ch #(
  parameter bit IS_CHAN_A = 1'b1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // Control
  input wire logic [1:0] out_mode_x,
  input wire logic [1:0] wave_kind,
  input wire logic wave_gen_mode_top_bit,
  // Match and bottom events qualified by the timer tick, plus TOP match and direction
  input wire logic match_evt,
  input wire logic bottom_evt,
  input wire logic match_at_top,
  input wire logic count_down,
  // Pin side
  input wire logic port_dir_out,
  input wire logic port_data,
  output logic pin_out,
  output logic pin_oe,
  output logic wave_level
);
  logic wave;
  logic next_wave;
  logic connected;
  logic do_toggle;
  logic do_set;
  logic do_clear;
  logic fast_mode;
  logic dual_mode;
  logic pwm_toggle_ok;

  assign fast_mode = wave_kind == tmr_pkg::TMR_WAVE_FAST;
  assign dual_mode = wave_kind == tmr_pkg::TMR_WAVE_DUAL;
  assign pwm_toggle_ok = wave_gen_mode_top_bit && IS_CHAN_A;
  // Mode one in PWM modes connects only channel A with the top bit set.
  assign connected = (out_mode_x != tmr_pkg::TMR_OUT_OFF) &&
    !((fast_mode || dual_mode) && out_mode_x == tmr_pkg::TMR_OUT_TOGGLE &&
    !pwm_toggle_ok);
  assign do_toggle = match_evt && out_mode_x == tmr_pkg::TMR_OUT_TOGGLE &&
    (!(fast_mode || dual_mode) || pwm_toggle_ok);
  // Fast PWM clear and set modes ignore a match at TOP but still act at BOTTOM.
  logic fast_match;
  assign fast_match = match_evt && !(match_at_top && out_mode_x[1]);
  always_comb begin
    do_set = 1'b0;
    do_clear = 1'b0;
    case (wave_kind)
      tmr_pkg::TMR_WAVE_NONPWM: begin
        do_set = match_evt && out_mode_x == tmr_pkg::TMR_OUT_SET;
        do_clear = match_evt && out_mode_x == tmr_pkg::TMR_OUT_CLEAR;
      end
      tmr_pkg::TMR_WAVE_FAST: begin
        if (out_mode_x == tmr_pkg::TMR_OUT_CLEAR) begin
          do_clear = fast_match;
          do_set = bottom_evt && !fast_match;
        end else if (out_mode_x == tmr_pkg::TMR_OUT_SET) begin
          do_set = fast_match;
          do_clear = bottom_evt && !fast_match;
        end
      end
      tmr_pkg::TMR_WAVE_DUAL: begin
        if (out_mode_x == tmr_pkg::TMR_OUT_CLEAR) begin
          do_clear = match_evt && !count_down;
          do_set = match_evt && count_down;
        end else if (out_mode_x == tmr_pkg::TMR_OUT_SET) begin
          do_set = match_evt && !count_down;
          do_clear = match_evt && count_down;
        end
      end
      default: begin
        do_set = 1'b0;
        do_clear = 1'b0;
      end
    endcase
  end
  assign next_wave = do_set ? 1'b1 : do_clear ? 1'b0 :
    do_toggle ? !wave : wave;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wave <= 1'b0;
    end else begin
      wave <= next_wave;
    end
  end
  assign wave_level = wave;
  assign pin_out = connected ? wave : port_data;
  assign pin_oe = port_dir_out;

  chk_set_match: assert property (@(posedge clock) disable iff (!nrst)
    (wave_kind == tmr_pkg::TMR_WAVE_NONPWM && match_evt &&
    out_mode_x == tmr_pkg::TMR_OUT_SET) |=> wave)
    else $error("wave not set on match");
  chk_dual_up_clear: assert property (@(posedge clock) disable iff (!nrst)
    (dual_mode && match_evt && !count_down &&
    out_mode_x == tmr_pkg::TMR_OUT_CLEAR) |=> !wave)
    else $error("wave not cleared on up match");
  chk_fast_bottom: assert property (@(posedge clock) disable iff (!nrst)
    (fast_mode && bottom_evt && !match_evt &&
    out_mode_x == tmr_pkg::TMR_OUT_CLEAR) |=> wave)
    else $error("wave not set at bottom");
  chk_oe_follows_dir: assert property (@(posedge clock) disable iff (!nrst)
    pin_oe == port_dir_out)
    else $error("pin driver not tied to direction");
endmodule : tmr_wave_ch

// ==== tmr_byte_access.sv ====
// Timer 16-bit register file with byte access and compare outputs.
// Functional notes
// - Synchronous design, tick is only an enable.
// - Dual-slope frequency-correct mode updates at BOTTOM.
// - One shared high-byte latch per timer.
// - Low-byte write loads latch plus low byte.
// - Low-byte read copies high byte into latch.
// - Compare high bytes read directly.
// - Nonzero output mode overrides the port, except PWM mode one on B or with the top bit clear.
// - Pin driver follows the direction bit.
// - Waveform mode selects output mode meaning.
// - Non-PWM: off, toggle, clear, set.
// - Fast PWM: match and BOTTOM actions.
// - PWM mode one: toggle A only, and only with the top mode bit set.
// - Dual-slope: up and down match actions.
// - Fast PWM clear and set modes ignore match at TOP.
// - Mode field split across control A and B.
// - Count write blocks next tick's match.
`timescale 1ns/10ps
`include "tmr_defines.svh"
module tmr_byte_access #(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic nrst,
  // CPU I/O bus
  input wire logic [5:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  // Counter core side
  input wire logic timer_tick,
  input wire logic [WIDTH-1:0] count_in,
  input wire logic count_down,
  input wire logic [WIDTH-1:0] top_value,
  input wire logic [WIDTH-1:0] capture_in,
  input wire logic capture_load,
  output logic [WIDTH-1:0] timer_count,
  output logic count_load,
  output logic [WIDTH-1:0] compare_value_a,
  output logic [WIDTH-1:0] compare_value_b,
  output logic [WIDTH-1:0] capture_value,
  output logic [3:0] wave_gen_mode,
  output logic [7:0] timer1_control_b,
  // Port and pin side
  input wire logic [1:0] port_dir_out,
  input wire logic [1:0] port_data,
  output logic wave_out_a,
  output logic wave_out_b,
  output logic wave_oe_a,
  output logic wave_oe_b
);
  logic [7:0] high_latch;
  logic [7:0] timer1_control_a;
  logic [WIDTH-1:0] cmp_buf_a;
  logic [WIDTH-1:0] cmp_buf_b;
  logic [WIDTH-1:0] wr_word;
  logic block_match;
  logic [1:0] wave_kind;
  logic update_now;
  logic upd_at_bottom;
  logic upd_immediate;
  logic at_bottom;
  logic at_top;
  logic match_a;
  logic match_b;
  logic bottom_evt;

  function automatic logic hit(input logic [5:0] a, input logic [5:0] b,
      input logic s);
    hit = s && (a == b);
  endfunction : hit

  logic wr_cnt_l;
  logic wr_cnt_h;
  logic wr_cmpa_l;
  logic wr_cmpb_l;
  logic wr_capt_l;
  logic rd_low16;
  logic [7:0] rd_high_src;
  assign wr_cnt_l = hit(io_addr, `TMR_ADDR_COUNT_L, io_wr);
  assign wr_cnt_h = hit(io_addr, `TMR_ADDR_COUNT_H, io_wr);
  assign wr_cmpa_l = hit(io_addr, `TMR_ADDR_CMPA_L, io_wr);
  assign wr_cmpb_l = hit(io_addr, `TMR_ADDR_CMPB_L, io_wr);
  assign wr_capt_l = hit(io_addr, `TMR_ADDR_CAPT_L, io_wr);
  assign wr_word = {high_latch, io_wdata};
  // Any high-byte write lands in the one shared latch.
  logic wr_any_h;
  assign wr_any_h = io_wr && (io_addr == `TMR_ADDR_COUNT_H ||
    io_addr == `TMR_ADDR_CMPA_H || io_addr == `TMR_ADDR_CMPB_H ||
    io_addr == `TMR_ADDR_CAPT_H);
  assign rd_low16 = io_rd && (io_addr == `TMR_ADDR_COUNT_L ||
    io_addr == `TMR_ADDR_CMPA_L || io_addr == `TMR_ADDR_CMPB_L ||
    io_addr == `TMR_ADDR_CAPT_L);
  assign rd_high_src = io_addr == `TMR_ADDR_COUNT_L ? count_in[15:8] :
    io_addr == `TMR_ADDR_CMPA_L ? compare_value_a[15:8] :
    io_addr == `TMR_ADDR_CMPB_L ? compare_value_b[15:8] :
    capture_value[15:8];

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      high_latch <= 8'h00;
    end else if (wr_any_h) begin
      high_latch <= io_wdata;
    end else if (rd_low16) begin
      high_latch <= rd_high_src;
    end
  end

  // Mode split: low bits in control A, high bits in control B.
  assign wave_gen_mode = {timer1_control_b[`TMR_WGM_HI_HI:`TMR_WGM_HI_LO],
    timer1_control_a[`TMR_WGM_LO_HI:0]};
  assign wave_kind = (wave_gen_mode == 4'h0 || wave_gen_mode == 4'h4 ||
    wave_gen_mode == 4'hc || wave_gen_mode == 4'hd) ?
    tmr_pkg::TMR_WAVE_NONPWM :
    (wave_gen_mode == 4'h5 || wave_gen_mode == 4'h6 ||
    wave_gen_mode == 4'h7 || wave_gen_mode == 4'he ||
    wave_gen_mode == 4'hf) ? tmr_pkg::TMR_WAVE_FAST :
    tmr_pkg::TMR_WAVE_DUAL;
  assign at_bottom = count_in == `TMR_BOTTOM;
  assign at_top = count_in == top_value;
  assign upd_immediate = wave_kind == tmr_pkg::TMR_WAVE_NONPWM;
  assign upd_at_bottom = wave_gen_mode == 4'h8 || wave_gen_mode == 4'h9;
  // Double-buffered compares change only on a tick at the update point.
  assign update_now = timer_tick &&
    (upd_at_bottom ? at_bottom : at_top);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      timer1_control_a <= `TMR_CTRL_RESET;
      timer1_control_b <= `TMR_CTRL_RESET;
      cmp_buf_a <= 16'h0000;
      cmp_buf_b <= 16'h0000;
      compare_value_a <= 16'h0000;
      compare_value_b <= 16'h0000;
      capture_value <= 16'h0000;
      timer_count <= 16'h0000;
      count_load <= 1'b0;
      block_match <= 1'b0;
    end else begin
      if (hit(io_addr, `TMR_ADDR_CTRL_A, io_wr)) begin
        timer1_control_a <= io_wdata;
      end
      if (hit(io_addr, `TMR_ADDR_CTRL_B, io_wr)) begin
        timer1_control_b <= io_wdata & `TMR_CTRL_B_MASK;
      end
      if (wr_cmpa_l) begin
        cmp_buf_a <= wr_word;
      end
      if (wr_cmpb_l) begin
        cmp_buf_b <= wr_word;
      end
      if (upd_immediate && wr_cmpa_l) begin
        compare_value_a <= wr_word;
      end else if (!upd_immediate && update_now) begin
        compare_value_a <= cmp_buf_a;
      end
      if (upd_immediate && wr_cmpb_l) begin
        compare_value_b <= wr_word;
      end else if (!upd_immediate && update_now) begin
        compare_value_b <= cmp_buf_b;
      end
      if (wr_capt_l) begin
        capture_value <= wr_word;
      end else if (capture_load) begin
        capture_value <= capture_in;
      end
      count_load <= wr_cnt_l;
      if (wr_cnt_l) begin
        timer_count <= wr_word;
      end
      // A count write holds off matches until the next tick is spent.
      if (wr_cnt_l) begin
        block_match <= 1'b1;
      end else if (timer_tick) begin
        block_match <= 1'b0;
      end
    end
  end

  assign match_a = timer_tick && !block_match && !wr_cnt_l &&
    count_in == compare_value_a;
  assign match_b = timer_tick && !block_match && !wr_cnt_l &&
    count_in == compare_value_b;
  assign bottom_evt = timer_tick && at_bottom;

  // Read mux: compare high bytes come straight from the registers.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      io_rdata <= 8'h00;
    end else if (io_rd) begin
      case (io_addr)
        `TMR_ADDR_CTRL_A: io_rdata <= timer1_control_a;
        `TMR_ADDR_CTRL_B: io_rdata <= timer1_control_b;
        `TMR_ADDR_COUNT_L: io_rdata <= count_in[7:0];
        `TMR_ADDR_CMPA_L: io_rdata <= compare_value_a[7:0];
        `TMR_ADDR_CMPB_L: io_rdata <= compare_value_b[7:0];
        `TMR_ADDR_CAPT_L: io_rdata <= capture_value[7:0];
        `TMR_ADDR_CMPA_H: io_rdata <= compare_value_a[15:8];
        `TMR_ADDR_CMPB_H: io_rdata <= compare_value_b[15:8];
        `TMR_ADDR_COUNT_H: io_rdata <= high_latch;
        `TMR_ADDR_CAPT_H: io_rdata <= high_latch;
        default: io_rdata <= 8'h00;
      endcase
    end
  end

  tmr_wave_ch #(.IS_CHAN_A(1'b1)) u_ch_a (
    .clock(clock),
    .nrst(nrst),
    .out_mode_x(timer1_control_a[`TMR_MODE_A_HI:`TMR_MODE_A_LO]),
    .wave_kind(wave_kind),
    .wave_gen_mode_top_bit(wave_gen_mode[3]),
    .match_evt(match_a),
    .bottom_evt(bottom_evt),
    .match_at_top(compare_value_a == top_value),
    .count_down(count_down),
    .port_dir_out(port_dir_out[0]),
    .port_data(port_data[0]),
    .pin_out(wave_out_a),
    .pin_oe(wave_oe_a),
    .wave_level()
  );
  tmr_wave_ch #(.IS_CHAN_A(1'b0)) u_ch_b (
    .clock(clock),
    .nrst(nrst),
    .out_mode_x(timer1_control_a[`TMR_MODE_B_HI:`TMR_MODE_B_LO]),
    .wave_kind(wave_kind),
    .wave_gen_mode_top_bit(wave_gen_mode[3]),
    .match_evt(match_b),
    .bottom_evt(bottom_evt),
    .match_at_top(compare_value_b == top_value),
    .count_down(count_down),
    .port_dir_out(port_dir_out[1]),
    .port_data(port_data[1]),
    .pin_out(wave_out_b),
    .pin_oe(wave_oe_b),
    .wave_level()
  );

  chk_low_write_word: assert property (@(posedge clock) disable iff (!nrst)
    (wr_cmpa_l && upd_immediate) |=>
    compare_value_a == {$past(high_latch), $past(io_wdata)})
    else $error("low write did not load whole word");
  chk_read_latches: assert property (@(posedge clock) disable iff (!nrst)
    (rd_low16 && !wr_any_h && io_addr == `TMR_ADDR_COUNT_L) |=>
    high_latch == $past(count_in[15:8]))
    else $error("low read did not latch high byte");
  chk_cmp_high_direct: assert property (@(posedge clock) disable iff (!nrst)
    (io_rd && io_addr == `TMR_ADDR_CMPB_H) |=>
    io_rdata == $past(compare_value_b[15:8]))
    else $error("compare high read used the latch");
  chk_shared_latch: assert property (@(posedge clock) disable iff (!nrst)
    wr_any_h |=> high_latch == $past(io_wdata))
    else $error("high byte not held in latch");
  chk_block_after_wr: assert property (@(posedge clock) disable iff (!nrst)
    wr_cnt_l ##1 (!wr_cnt_l && timer_tick)[*1] |-> !match_a)
    else $error("match not blocked after count write");
  chk_pfc_hold: assert property (@(posedge clock) disable iff (!nrst)
    (upd_at_bottom && !(timer_tick && at_bottom)) |=>
    $stable(compare_value_a))
    else $error("compare changed away from bottom");
  chk_reset_modes: assert property (@(posedge clock)
    $rose(nrst) |-> timer1_control_a[7:4] == 4'h0)
    else $error("output modes not zero after reset");
  chk_mode_split: assert property (@(posedge clock) disable iff (!nrst)
    wave_gen_mode[1:0] == timer1_control_a[1:0])
    else $error("mode low bits misplaced");
  cov_word_write: cover property (@(posedge clock) disable iff (!nrst)
    wr_cnt_h ##1 wr_cnt_l);
  cov_word_read: cover property (@(posedge clock) disable iff (!nrst)
    (io_rd && io_addr == `TMR_ADDR_COUNT_L) ##1
    (io_rd && io_addr == `TMR_ADDR_COUNT_H));
  cov_pfc_update: cover property (@(posedge clock) disable iff (!nrst)
    upd_at_bottom && update_now);
  // The counter core only sees timer_count through count_load, so the
  // whole-word load is checked here rather than through a read.
  chk_count_write: assert property (@(posedge clock) disable iff (!nrst)
    wr_cnt_l |=> (count_load &&
    timer_count == {$past(high_latch), $past(io_wdata)}))
    else $error("count low write did not load whole word");
  chk_capt_high_latch: assert property (@(posedge clock) disable iff (!nrst)
    (io_rd && io_addr == `TMR_ADDR_CAPT_H) |=>
    io_rdata == $past(high_latch))
    else $error("capture high read bypassed the latch");
  // Buffered compares may only move on a tick; a change between ticks
  // would shift a pulse edge by part of a timer period.
  chk_buf_on_tick: assert property (@(posedge clock) disable iff (!nrst)
    (!upd_immediate && !timer_tick) |=> $stable(compare_value_a))
    else $error("buffered compare moved without a tick");
  chk_pfc_update: assert property (@(posedge clock) disable iff (!nrst)
    (upd_at_bottom && timer_tick && at_bottom) |=>
    compare_value_a == $past(cmp_buf_a))
    else $error("compare not loaded from buffer at bottom");
  chk_block_late_tick: assert property (@(posedge clock) disable iff (!nrst)
    wr_cnt_l ##1 (!wr_cnt_l && !timer_tick) ##1 timer_tick |->
    (!match_a && !match_b))
    else $error("match not blocked on first tick after count write");
  cov_count_block: cover property (@(posedge clock) disable iff (!nrst)
    wr_cnt_l ##2 timer_tick);
endmodule : tmr_byte_access

// ==== tmr_cpu_model.sv ====
// CPU-side bus model with byte and atomic 16-bit register access tasks.
`timescale 1ns/10ps
module tmr_cpu_model (
  // Clock
  input wire logic clock,
  // CPU I/O bus
  output logic [5:0] io_addr,
  output logic io_wr,
  output logic io_rd,
  output logic [7:0] io_wdata,
  input wire logic [7:0] io_rdata
);
  initial begin
    io_addr = 6'h3f;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end

  // Released write data is inverted so a stale byte never looks valid.
  task automatic wr8(input logic [5:0] a, input logic [7:0] d);
    @(negedge clock);
    io_addr = a;
    io_wdata = d;
    io_wr = 1'b1;
    @(negedge clock);
    io_wr = 1'b0;
    io_wdata = ~d;
  endtask : wr8

  task automatic rd8(input logic [5:0] a, output logic [7:0] d);
    @(negedge clock);
    io_addr = a;
    io_rd = 1'b1;
    @(negedge clock);
    io_rd = 1'b0;
    d = io_rdata;
  endtask : rd8

  // Interrupts count as masked for the whole pair, so nothing else can
  // reach the shared latch between the two byte accesses.
  task automatic wr16(input logic [5:0] a, input logic [15:0] d);
    wr8(a + 6'h01, d[15:8]);
    wr8(a, d[7:0]);
  endtask : wr16

  task automatic rd16(input logic [5:0] a, output logic [15:0] d);
    rd8(a, d[7:0]);
    rd8(a + 6'h01, d[15:8]);
  endtask : rd16

  // One high byte serves two low-byte writes, still as one atomic run.
  task automatic wr_two(input logic [5:0] a0, input logic [5:0] a1,
    input logic [7:0] hi, input logic [7:0] lo0, input logic [7:0] lo1);
    wr8(a0 + 6'h01, hi);
    wr8(a0, lo0);
    wr8(a1, lo1);
  endtask : wr_two
endmodule : tmr_cpu_model

// ==== test_tmr_byte_access.sv ====
// Self-checking bench for the timer byte access and compare outputs.
`timescale 1ns/10ps
`include "tmr_defines.svh"
module test_tmr_byte_access;
  logic clock;
  logic nrst;
  logic timer_tick;
  logic count_down;
  logic capture_load;
  logic [15:0] count_in;
  logic [15:0] top_value;
  logic [15:0] capture_in;
  logic [1:0] port_dir_out;
  logic [1:0] port_data;
  logic [5:0] io_addr;
  logic io_wr;
  logic io_rd;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic [15:0] timer_count;
  logic count_load;
  logic [15:0] compare_value_a;
  logic [15:0] compare_value_b;
  logic [15:0] capture_value;
  logic [3:0] wave_gen_mode;
  logic [7:0] timer1_control_b;
  logic wave_out_a;
  logic wave_out_b;
  logic wave_oe_a;
  logic wave_oe_b;
  logic [7:0] b;
  logic [15:0] w;
  logic [1:0] codes [4];
  logic exp_lvl [4];
  int failures;
  int n_checks;

  tmr_cpu_model i_cpu (.clock(clock), .io_addr(io_addr), .io_wr(io_wr),
    .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata));

  tmr_byte_access #(.WIDTH(16)) i_dut (.clock(clock), .nrst(nrst),
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata),
    .io_rdata(io_rdata), .timer_tick(timer_tick), .count_in(count_in),
    .count_down(count_down), .top_value(top_value),
    .capture_in(capture_in), .capture_load(capture_load),
    .timer_count(timer_count), .count_load(count_load),
    .compare_value_a(compare_value_a), .compare_value_b(compare_value_b),
    .capture_value(capture_value), .wave_gen_mode(wave_gen_mode),
    .timer1_control_b(timer1_control_b), .port_dir_out(port_dir_out),
    .port_data(port_data), .wave_out_a(wave_out_a),
    .wave_out_b(wave_out_b), .wave_oe_a(wave_oe_a), .wave_oe_b(wave_oe_b));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic print_verdict;
    $display("Checks %0d, failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : print_verdict

  // One timer tick with the given count value and direction.
  task automatic tick(input logic [15:0] c, input logic dn);
    @(negedge clock);
    count_in = c;
    count_down = dn;
    timer_tick = 1'b1;
    @(negedge clock);
    timer_tick = 1'b0;
    @(negedge clock);
  endtask : tick

  initial begin
    repeat (20000) @(posedge clock);
    failures++;
    print_verdict();
  end

  initial begin
    nrst = 1'b0;
    timer_tick = 1'b0;
    count_down = 1'b0;
    capture_load = 1'b0;
    count_in = 16'h3c5a;
    top_value = 16'hffff;
    capture_in = 16'h9e21;
    port_dir_out = 2'b11;
    port_data = 2'b01;
    codes = '{2'b11, 2'b10, 2'b01, 2'b01};
    exp_lvl = '{1'b1, 1'b0, 1'b1, 1'b0};
    repeat (3) @(negedge clock);
    nrst = 1'b1;
    check({14'h0000, wave_out_b, wave_out_a}, 16'h0001);
    check({14'h0000, wave_oe_b, wave_oe_a}, 16'h0003);
    i_cpu.rd8(`TMR_ADDR_CTRL_A, b);
    check({8'h00, b}, 16'h0000);
    i_cpu.rd8(6'h3f, b);
    check({8'h00, b}, 16'h0000);
    i_cpu.wr16(`TMR_ADDR_COUNT_L, 16'h3c5a);
    check({15'h0000, count_load}, 16'h0001);
    check(timer_count, 16'h3c5a);
    i_cpu.rd16(`TMR_ADDR_COUNT_L, w);
    check(w, 16'h3c5a);
    i_cpu.wr_two(`TMR_ADDR_CMPA_L, `TMR_ADDR_CMPB_L, 8'h00, 8'h10, 8'h20);
    check(compare_value_a, 16'h0010);
    check(compare_value_b, 16'h0020);
    @(negedge clock);
    capture_load = 1'b1;
    @(negedge clock);
    capture_load = 1'b0;
    @(negedge clock);
    check(capture_value, 16'h9e21);
    // The capture low read leaves 9e in the latch; the compare high read
    // must bypass it and the count high read must return it.
    i_cpu.rd8(`TMR_ADDR_CAPT_L, b);
    check({8'h00, b}, 16'h0021);
    i_cpu.rd8(`TMR_ADDR_CMPA_H, b);
    check({8'h00, b}, 16'h0000);
    i_cpu.rd8(`TMR_ADDR_COUNT_H, b);
    check({8'h00, b}, 16'h009e);
    i_cpu.wr16(`TMR_ADDR_CAPT_L, 16'h1234);
    check(capture_value, 16'h1234);
    i_cpu.wr8(`TMR_ADDR_CMPB_H, 8'h77);
    check(compare_value_b, 16'h0020);
    i_cpu.rd16(`TMR_ADDR_CAPT_L, w);
    check(w, 16'h1234);
    i_cpu.wr8(`TMR_ADDR_CTRL_B, 8'hff);
    i_cpu.rd8(`TMR_ADDR_CTRL_B, b);
    check({8'h00, b}, 16'h00df);
    check({8'h00, timer1_control_b}, 16'h00df);
    check({12'h000, wave_gen_mode}, 16'h000c);
    i_cpu.wr8(`TMR_ADDR_CTRL_B, 8'h00);
    port_data = 2'b10;
    tick(16'h0000, 1'b0);
    for (int i = 0; i < 4; i++) begin
      i_cpu.wr8(`TMR_ADDR_CTRL_A, {codes[i], 6'h00});
      tick(16'h0010, 1'b0);
      check({15'h0000, wave_out_a}, {15'h0000, exp_lvl[i]});
    end
    check({15'h0000, wave_out_b}, 16'h0001);
    port_dir_out = 2'b00;
    #1 check({15'h0000, wave_oe_a}, 16'h0000);
    check({15'h0000, wave_oe_b}, 16'h0000);
    @(negedge clock);
    port_dir_out = 2'b11;
    i_cpu.wr16(`TMR_ADDR_COUNT_L, 16'h0010);
    tick(16'h0010, 1'b0);
    check({15'h0000, wave_out_a}, 16'h0000);
    tick(16'h0010, 1'b0);
    check({15'h0000, wave_out_a}, 16'h0001);
    top_value = 16'h00ff;
    i_cpu.wr8(`TMR_ADDR_CTRL_B, 8'h18);
    i_cpu.wr8(`TMR_ADDR_CTRL_A, 8'h92);
    check({12'h000, wave_gen_mode}, 16'h000e);
    tick(16'h0010, 1'b0);
    check({15'h0000, wave_out_a}, 16'h0000);
    check({15'h0000, wave_out_b}, 16'h0001);
    tick(16'h0000, 1'b0);
    check({15'h0000, wave_out_a}, 16'h0001);
    top_value = 16'h0010;
    i_cpu.wr8(`TMR_ADDR_CTRL_A, 8'hc2);
    tick(16'h0000, 1'b0);
    check({15'h0000, wave_out_a}, 16'h0000);
    tick(16'h0010, 1'b0);
    check({15'h0000, wave_out_a}, 16'h0000);
    top_value = 16'h00ff;
    i_cpu.wr8(`TMR_ADDR_CTRL_A, 8'h52);
    tick(16'h0010, 1'b0);
    check({15'h0000, wave_out_a}, 16'h0001);
    check({15'h0000, wave_out_b}, 16'h0001);
    i_cpu.wr8(`TMR_ADDR_CTRL_B, 8'h10);
    i_cpu.wr8(`TMR_ADDR_CTRL_A, 8'h80);
    check({12'h000, wave_gen_mode}, 16'h0008);
    tick(16'h0010, 1'b0);
    check({15'h0000, wave_out_a}, 16'h0000);
    tick(16'h0010, 1'b1);
    check({15'h0000, wave_out_a}, 16'h0001);
    i_cpu.wr8(`TMR_ADDR_CTRL_A, 8'hc0);
    tick(16'h0010, 1'b1);
    check({15'h0000, wave_out_a}, 16'h0000);
    tick(16'h0010, 1'b0);
    check({15'h0000, wave_out_a}, 16'h0001);
    i_cpu.wr16(`TMR_ADDR_CMPA_L, 16'h0030);
    tick(16'h0005, 1'b0);
    check(compare_value_a, 16'h0010);
    tick(16'h0000, 1'b0);
    check(compare_value_a, 16'h0030);
    print_verdict();
  end
endmodule : test_tmr_byte_access
